// ==== shared/fuse_loader_pkg.sv ====
// constants, field layouts and carriers for the configuration fuse loader
// What this block does
// - at reset copy watchdog fuse bits 7:4 into watchdog window field
// - at reset copy watchdog fuse bits 3:0 into watchdog period field
// - at power-up load every brown-out fuse field into detector control registers
// - threshold bits 7:5 go to second control register; codes above 3 reserved
// - sample-rate bit goes to first control register; 0 is 128 Hz, 1 is 32 Hz
// - two-bit active/idle brown-out mode goes to first control register
// - active codes: off, continuous, sampled, continuous with hold until ready
// - sleep mode bits 1:0 go to first control register; code 3 reserved
// - oscillator choice bits 3:0: 0 fast internal, 1 slow internal, others reserved
// - scan region bits 7:6: full, boot, boot plus app, none
// - scan algorithm bit 5: 0 sixteen-bit CRC, 1 thirty-two-bit CRC
// - reset pin bits 3:2: 0 plain input, 2 external reset, others reserved
// - eeprom preserve bit 0: clear erases eeprom on chip erase, set keeps it
// - when locked, chip erase always erases eeprom
// - startup delay code 0 none, codes 1 to 7 give 1 ms doubling to 64 ms
// - shipped fuse values are not reset values; system byte a ships 0xC0
// - processor and debug port read fuses; only programmer may write them
// - new fuse values act only after the next reset
// - boot region length counts 512-byte blocks; zero means whole flash
package fuse_loader_pkg;
   localparam logic [3:0] OFF_WATCHDOG = 4'h0;
   localparam logic [3:0] OFF_BROWNOUT = 4'h1;
   localparam logic [3:0] OFF_OSCILLATOR = 4'h2;
   localparam logic [3:0] OFF_SYSCFG_A = 4'h5;
   localparam logic [3:0] OFF_SYSCFG_B = 4'h6;
   localparam logic [3:0] OFF_CODE_LEN = 4'h7;
   localparam logic [3:0] OFF_BOOT_LEN = 4'h8;
   localparam logic [3:0] OFF_LAST = 4'h8;
   localparam int NUM_FUSES = 9;

   localparam logic [7:0] SHIP_SYSCFG_A = 8'hc0;
   localparam logic [7:0] SHIP_OTHER = 8'h00;

   localparam logic [2:0] THRESH_MAX = 3'h3;
   localparam logic [1:0] SLEEP_RESERVED = 2'h3;
   localparam logic [3:0] OSC_FAST = 4'h0;
   localparam logic [3:0] OSC_SLOW = 4'h1;
   localparam logic [1:0] PIN_INPUT = 2'h0;
   localparam logic [1:0] PIN_RESET = 2'h2;
   localparam int BOOT_BLOCK_BYTES = 512;

   localparam int CLK_MHZ = 100;
   localparam int STARTUP_UNIT_MS = 1;
   localparam int CYCLES_PER_MS = STARTUP_UNIT_MS * CLK_MHZ * 1000;
   localparam logic [22:0] CYC_PER_MS = 23'(CYCLES_PER_MS);
   localparam int STARTUP_MAX_MS = 64;

   typedef struct packed {
      logic [3:0] window;
      logic [3:0] period;
   } watchdog_ctrl_s;

   typedef struct packed {
      logic sample_rate;
      logic [1:0] active_mode;
      logic [1:0] sleep_mode;
   } brownout_ctrl_a_s;

   typedef struct packed {
      watchdog_ctrl_s watchdog;
      brownout_ctrl_a_s bod_a;
      logic [2:0] bod_threshold;
      logic bod_hold_until_ready;
      logic [3:0] oscillator_choice;
      logic osc_reserved;
      logic [1:0] scan_region_select;
      logic scan_algorithm_select;
      logic scan_enable;
      logic [1:0] reset_pin_function;
      logic ext_reset_enable;
      logic eeprom_erase_on_chip_erase;
      logic [7:0] code_len;
      logic [7:0] boot_len;
      logic boot_is_whole_flash;
      logic cfg_error;
   } loaded_cfg_s;

   typedef enum logic [1:0] {ST_LOAD, ST_DELAY, ST_RUN} load_state_e;
endpackage : fuse_loader_pkg

// ==== verification/fuse_array_model.sv ====
// fuse array stand-in with a combinational read port
`timescale 1ns/100ps
module fuse_array_model (
   input wire logic [3:0] fuse_addr,
   output logic [7:0] fuse_rdata
);
   logic [7:0] mem [0:15];
   assign fuse_rdata = mem[fuse_addr];
endmodule : fuse_array_model

// ==== verification/fuse_config_loader_bench.sv ====
// self-checking bench for the fuse configuration loader
`timescale 1ns/100ps
module fuse_config_loader_bench;
   import fuse_loader_pkg::*;
   logic core_clk = 0, rst_b = 0, device_locked = 0, chip_erase_req = 0;
   logic [3:0] fuse_addr, cpu_rd_addr = 4'h0;
   logic [7:0] fuse_rdata, cpu_rd_data;
   logic eeprom_erase, cfg_valid, cpu_reset_release;
   loaded_cfg_s cfg, e;
   int err_total = 0, comparisons = 0, n;
   // reserved bits stay zero; first image is the shipped one
   logic [7:0] imgs [3][9] = '{'{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h00, 8'h00},
      '{8'ha5, 8'h7f, 8'h01, 8'h00, 8'h00, 8'h2d, 8'h00, 8'h40, 8'h10},
      '{8'h3c, 8'h96, 8'h05, 8'h00, 8'h00, 8'h89, 8'h00, 8'hff, 8'h01}};
   always #5 core_clk = ~core_clk;
   fuse_config_loader fuse_config_loader_i (.*);
   fuse_array_model fuse_array_model_i (.*);
   task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic close_out();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   task automatic cpu_read(logic [3:0] a, logic [7:0] exp);
      @(posedge core_clk) cpu_rd_addr <= a;
      @(posedge core_clk) #1 check("cpu read", cpu_rd_data, exp);
   endtask : cpu_read
   task automatic erase(logic lock, logic exp);
      @(posedge core_clk);
      device_locked <= lock;
      chip_erase_req <= 1'b1;
      @(posedge core_clk) #1 check("eeprom erase", eeprom_erase, exp);
      @(posedge core_clk) chip_erase_req <= 1'b0;
   endtask : erase
   initial begin
      for (int i = 0; i < 3; i++) begin
         foreach (imgs[i][k]) fuse_array_model_i.mem[k] = imgs[i][k];
         @(posedge core_clk) rst_b <= 1'b0;
         repeat (20) @(posedge core_clk);
         check("reset outputs", {cfg, cfg_valid, cpu_reset_release}, 0);
         rst_b <= 1'b1;
         n = 0;
         while (!cpu_reset_release && n < 60) begin
            @(posedge core_clk) #1 n++;
         end
         // a hang counts once here and the edge check below records it too
         if (n == 60) begin
            err_total++;
         end
         check("release edge", n, 11);
         e = '{imgs[i][0], imgs[i][1][4:0], imgs[i][1][7:5], imgs[i][1][3:2] == 2'h3,
            imgs[i][2][3:0], imgs[i][2][3:0] > 4'h1, imgs[i][5][7:6], imgs[i][5][5],
            imgs[i][5][7:6] != 2'h3, imgs[i][5][3:2], imgs[i][5][3:2] == 2'h2, !imgs[i][5][0],
            imgs[i][7], imgs[i][8], imgs[i][8] == 8'h00,
            imgs[i][1][7:5] > 3'h3 || imgs[i][1][1:0] == 2'h3 || imgs[i][5][2]};
         check("loaded fields", cfg, e);
         // a late fuse change must not reach the shadow or the controls
         fuse_array_model_i.mem[0] = ~imgs[i][0];
         for (int k = 0; k < 16; k++) cpu_read(k[3:0], k > 8 ? 8'h00 : imgs[i][k]);
         check("fields after change", cfg, e);
         erase(1'b0, !imgs[i][5][0]);
         erase(1'b1, 1'b1);
      end
      close_out();
   end
endmodule : fuse_config_loader_bench

// ==== verification/fuse_config_loader_properties.sv ====
// concurrent checks on the fuse loader ports
`timescale 1ns/100ps
module fuse_config_loader_properties
   import fuse_loader_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [3:0] fuse_addr,
   input wire logic [7:0] fuse_rdata,
   input wire logic [3:0] cpu_rd_addr,
   input wire logic [7:0] cpu_rd_data,
   input wire logic device_locked,
   input wire logic chip_erase_req,
   input wire logic eeprom_erase,
   input wire loaded_cfg_s cfg,
   input wire logic cfg_valid,
   input wire logic cpu_reset_release
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence s_release;
      !cpu_reset_release ##1 cpu_reset_release;
   endsequence
   chk_release_loaded: assert property (s_release |-> cfg_valid && $past(cfg_valid))
      else $error("release before load");
   chk_cfg_frozen: assert property (cfg_valid |=> cfg_valid && $stable(cfg))
      else $error("loaded fields moved");
   chk_erase_locked: assert property (cfg_valid && chip_erase_req && device_locked |=> eeprom_erase)
      else $error("locked erase kept eeprom");
   chk_erase_kept: assert property (cfg_valid && chip_erase_req && !device_locked
      && !cfg.eeprom_erase_on_chip_erase |=> !eeprom_erase) else $error("eeprom not kept");
   chk_hold_code: assert property (cfg_valid |-> cfg.bod_hold_until_ready
      == (cfg.bod_a.active_mode == 2'h3)) else $error("hold flag wrong");
   chk_scan_none: assert property (cfg_valid |-> cfg.scan_enable
      == (cfg.scan_region_select != 2'h3)) else $error("scan enable wrong");
   chk_pin_reset: assert property (cfg_valid |-> cfg.ext_reset_enable
      == (cfg.reset_pin_function == PIN_RESET)) else $error("reset pin wrong");
   chk_unmapped_read: assert property (cpu_rd_addr > OFF_LAST |=> cpu_rd_data == 8'h00)
      else $error("unmapped read not zero");
endmodule : fuse_config_loader_properties
bind fuse_config_loader fuse_config_loader_properties fuse_config_loader_properties_i (.*);

// ==== verilog/fuse_config_loader.sv ====
// configuration fuse loader: copies fuse bytes into peripheral controls at reset
`timescale 1ns/100ps
module fuse_config_loader
   import fuse_loader_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   output logic [3:0] fuse_addr,
   input wire logic [7:0] fuse_rdata,
   input wire logic [3:0] cpu_rd_addr,
   output logic [7:0] cpu_rd_data,
   input wire logic device_locked,
   input wire logic chip_erase_req,
   output logic eeprom_erase,
   output loaded_cfg_s cfg,
   output logic cfg_valid,
   output logic cpu_reset_release
);
   typedef struct packed {
      load_state_e state;
      logic [3:0] addr;
      // packed so the whole state stays one packed struct
      logic [NUM_FUSES-1:0][7:0] shadow;
      loaded_cfg_s cfg;
      logic cfg_valid;
      logic [6:0] ms_left;
      logic [22:0] cyc;
      logic release_cpu;
      logic [7:0] rd_data;
      logic ee_erase;
   } state_s;
   state_s s_q, s_d;

   // delay in ms for each startup code; doubling from 1 ms
   function automatic logic [6:0] startup_ms(input logic [2:0] code);
      startup_ms = (code == 3'h0) ? 7'h00 : 7'(7'h01 << (code - 3'h1));
   endfunction : startup_ms

   function automatic logic [7:0] shadow_at(input logic [NUM_FUSES-1:0][7:0] sh,
                                            input logic [3:0] a);
      shadow_at = (a <= OFF_LAST) ? sh[a] : 8'h00;
   endfunction : shadow_at

   always_comb begin
      logic [7:0] wd;
      logic [7:0] bo;
      logic [7:0] sa;
      wd = s_q.shadow[OFF_WATCHDOG];
      bo = s_q.shadow[OFF_BROWNOUT];
      sa = s_q.shadow[OFF_SYSCFG_A];
      s_d = s_q;
      // fuse bytes are read-only to the processor; no write path exists here
      s_d.rd_data = shadow_at(s_q.shadow, cpu_rd_addr);
      s_d.ee_erase = chip_erase_req & (device_locked | ~sa[0]);
      case (s_q.state)
         ST_LOAD: begin
            s_d.shadow[s_q.addr] = fuse_rdata;
            if (s_q.addr == OFF_LAST) begin
               s_d.state = ST_DELAY;
            end else begin
               s_d.addr = s_q.addr + 4'h1;
            end
         end
         ST_DELAY: begin
            if (s_q.cfg_valid == 1'b0) begin
               // shadow now complete: build every control field at once
               s_d.cfg.watchdog.window = wd[7:4];
               s_d.cfg.watchdog.period = wd[3:0];
               s_d.cfg.bod_threshold = bo[7:5];
               s_d.cfg.bod_a.sample_rate = bo[4];
               s_d.cfg.bod_a.active_mode = bo[3:2];
               s_d.cfg.bod_hold_until_ready = (bo[3:2] == 2'h3);
               s_d.cfg.bod_a.sleep_mode = bo[1:0];
               s_d.cfg.oscillator_choice = s_q.shadow[OFF_OSCILLATOR][3:0];
               s_d.cfg.osc_reserved = s_q.shadow[OFF_OSCILLATOR][3:0] != OSC_FAST
                  && s_q.shadow[OFF_OSCILLATOR][3:0] != OSC_SLOW;
               s_d.cfg.scan_region_select = sa[7:6];
               s_d.cfg.scan_enable = (sa[7:6] != 2'h3);
               s_d.cfg.scan_algorithm_select = sa[5];
               s_d.cfg.reset_pin_function = sa[3:2];
               s_d.cfg.ext_reset_enable = (sa[3:2] == PIN_RESET);
               s_d.cfg.eeprom_erase_on_chip_erase = ~sa[0];
               s_d.cfg.code_len = s_q.shadow[OFF_CODE_LEN];
               s_d.cfg.boot_len = s_q.shadow[OFF_BOOT_LEN];
               s_d.cfg.boot_is_whole_flash = (s_q.shadow[OFF_BOOT_LEN] == 8'h00);
               // reserved codes are flagged, not corrected
               s_d.cfg.cfg_error = (bo[7:5] > THRESH_MAX)
                  | (bo[1:0] == SLEEP_RESERVED)
                  | (sa[3:2] != PIN_INPUT && sa[3:2] != PIN_RESET);
               s_d.cfg_valid = 1'b1;
               s_d.ms_left = startup_ms(s_q.shadow[OFF_SYSCFG_B][2:0]);
               s_d.cyc = CYC_PER_MS;
            end else if (s_q.ms_left == 7'h00) begin
               s_d.state = ST_RUN;
               s_d.release_cpu = 1'b1;
            end else if (s_q.cyc == 23'h00_0001) begin
               s_d.cyc = CYC_PER_MS;
               s_d.ms_left = s_q.ms_left - 7'h01;
            end else begin
               s_d.cyc = s_q.cyc - 23'h00_0001;
            end
         end
         ST_RUN: begin
            // fuse changes in the array are ignored until the next reset
            s_d.state = ST_RUN;
         end
         default: begin
            s_d.state = ST_LOAD;
         end
      endcase
   end

   // reset values are zero, not the shipped fuse contents
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         fuse_addr <= 4'h0;
      end else begin
         fuse_addr <= s_d.addr;
      end
   end

   assign cpu_rd_data = s_q.rd_data;
   assign eeprom_erase = s_q.ee_erase;
   assign cfg = s_q.cfg;
   assign cfg_valid = s_q.cfg_valid;
   assign cpu_reset_release = s_q.release_cpu;
endmodule : fuse_config_loader
